// *** verilog/lsg_regs.sv ***
// Decided for this implementation: the plain strobed port.
`include "lsg_defines.svh"

module lsg_regs
    import lsg_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       RST_N,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic [7:0]      RDATA,
    input  wire logic       LINE_ENABLE,
    input  wire logic       LINE_INTL,
    input  wire logic [3:0] LINE_REV,
    input  wire logic       LINE_PART_OK,
    input  wire logic       ON_HOOK,
    input  wire logic       MONITOR_ON,
    output logic            TX_MUTE,
    output logic [4:0]      TX_ATTEN_HDB,
    output logic            RX_MUTE,
    output logic [4:0]      RX_GAIN_HDB,
    output logic [5:0]      MON_ATTEN_TDB,
    output logic            MONITOR_SEL,
    output logic            DATA_ENABLE,
    output logic            IRQ
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic rst_meta_r;
    logic rst_sync_r;

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus request bundle and address decode
    lsg_bus_t   bus;
    wire logic  hit_ident;
    wire logic  hit_valid;
    wire logic  hit_gain;
    wire logic  hit_stat;
    wire logic  hit_mask;

    assign bus       = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
    assign hit_ident = (bus.addr == `LSG_OFS_IDENT);
    assign hit_valid = (bus.addr == `LSG_OFS_VALID);
    assign hit_gain  = (bus.addr == `LSG_OFS_GAIN);
    assign hit_stat  = (bus.addr == `LSG_OFS_IRQ_STAT);
    assign hit_mask  = (bus.addr == `LSG_OFS_IRQ_MASK);

    ////////////////////////////////////////////////////////////////////////
    // Verification sequencer
    logic v_pending;
    logic v_running;
    logic v_wrong;
    logic v_done;

    lsg_verify u_verify (
        .clk        (MCLK),
        .rst_n      (rst_sync_r),
        .enable     (LINE_ENABLE),
        .part_ok    (LINE_PART_OK),
        .pending    (v_pending),
        .running    (v_running),
        .wrong      (v_wrong),
        .done_pulse (v_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // Writable registers
    logic [7:0] gain_r;
    logic [1:0] legacy_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_mask_r;
    logic [1:0] irq_set;
    logic [1:0] irq_clr;
    logic [1:0] irq_stat_nxt;

    // Events: check finished, wrong part found
    assign irq_set      = {v_done & ~LINE_PART_OK, v_done};
    assign irq_clr      = (bus.wr && hit_stat) ? bus.wdata[1:0] : 2'h0;
    assign irq_stat_nxt = (irq_stat_r & ~irq_clr) | irq_set;  // Set wins

    always_ff @(posedge MCLK or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            gain_r     <= `LSG_RST_GAIN;
            legacy_r   <= `LSG_RST_LEGACY;
            irq_stat_r <= `LSG_RST_IRQ;
            irq_mask_r <= `LSG_RST_IRQ;
        end else begin
            if (bus.wr && hit_gain)
                gain_r <= bus.wdata;
            if (bus.wr && hit_ident)
                legacy_r <= bus.wdata[1:0];
            if (bus.wr && hit_mask)
                irq_mask_r <= bus.wdata[1:0];
            irq_stat_r <= irq_stat_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data mux
    wire logic [7:0] ident_val;
    wire logic [7:0] valid_val;
    wire logic [7:0] rd_mux;
    logic [7:0]      rdata_r;

    assign ident_val = {1'b0,
                        LINE_INTL,
                        LINE_REV,
                        legacy_r};
    assign valid_val = {5'h00, v_pending, v_running, v_wrong};
    assign rd_mux    = hit_ident ? ident_val :
                       hit_valid ? valid_val :
                       hit_gain  ? gain_r :
                       hit_stat  ? {6'h00, irq_stat_r} :
                       hit_mask  ? {6'h00, irq_mask_r} :
                       8'h00;

    always_ff @(posedge MCLK or negedge rst_sync_r) begin
        if (!rst_sync_r)
            rdata_r <= 8'h00;
        else
            rdata_r <= bus.rd ? rd_mux : 8'h00;
    end

    assign RDATA = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Path settings decode
    lsg_path_t path;

    lsg_gain_map u_map (
        .gain_reg   (gain_r),
        .legacy     (legacy_r),
        .on_hook    (ON_HOOK),
        .monitor_on (MONITOR_ON),
        .path       (path)
    );

    ////////////////////////////////////////////////////////////////////////
    // Registered path outputs
    lsg_path_t path_r;
    logic      data_en_r;

    always_ff @(posedge MCLK or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            path_r    <= '0;
            data_en_r <= 1'b0;
        end else begin
            path_r    <= path;
            // Data flows only after a passing check
            data_en_r <= ~v_pending & ~v_running & ~v_wrong;
        end
    end

    assign TX_MUTE       = path_r.tx_mute;
    assign TX_ATTEN_HDB  = path_r.tx_atten_hdb;
    assign RX_MUTE       = path_r.rx_mute;
    assign RX_GAIN_HDB   = path_r.rx_gain_hdb;
    assign MON_ATTEN_TDB = path_r.mon_atten_tdb;
    assign MONITOR_SEL   = path_r.monitor_sel;
    assign DATA_ENABLE   = data_en_r;
    assign IRQ           = |(irq_stat_r & irq_mask_r);

endmodule

// *** verilog/lsg_defines.svh ***
`ifndef LSG_DEFINES_SVH
`define LSG_DEFINES_SVH

// Register offsets
`define LSG_OFS_IDENT     4'hD
`define LSG_OFS_VALID     4'hE
`define LSG_OFS_GAIN      4'hF
`define LSG_OFS_IRQ_STAT  4'h0
`define LSG_OFS_IRQ_MASK  4'h1

// Identity register fields
`define LSG_ID_VARIANT    6
`define LSG_ID_REV_HI     5
`define LSG_ID_REV_LO     2
`define LSG_ID_RXBOOST    1
`define LSG_ID_TXCUT      0

// Validation register fields
`define LSG_VAL_PENDING   2
`define LSG_VAL_RUNNING   1
`define LSG_VAL_WRONG     0

// Gain register fields
`define LSG_GN_TXMUTE     7
`define LSG_GN_TXSEL_HI   6
`define LSG_GN_TXSEL_LO   4
`define LSG_GN_RXMUTE     3
`define LSG_GN_RXSEL_HI   2
`define LSG_GN_RXSEL_LO   0

// Interrupt status bits
`define LSG_IRQ_DONE      0
`define LSG_IRQ_WRONG     1

// Reset values
`define LSG_RST_GAIN      8'h00
`define LSG_RST_LEGACY    2'h0
`define LSG_RST_IRQ       2'h0

// Verification check duration
`define LSG_CHECK_NS      64
`define LSG_CLK_NS        4
`define LSG_CHECK_CYC     ((`LSG_CHECK_NS + `LSG_CLK_NS - 1) / `LSG_CLK_NS)

`endif

// *** verilog/lsg_pkg.sv ***
package lsg_pkg;

    // Verification sequencer states
    typedef enum logic [1:0] {
        LSG_IDLE,
        LSG_RUN,
        LSG_DONE
    } lsg_state_t;

    // Gain levels in half-dB steps, monitor attenuation in tenths of dB
    typedef struct packed {
        logic       tx_mute;
        logic [4:0] tx_atten_hdb;
        logic       rx_mute;
        logic [4:0] rx_gain_hdb;
        logic [5:0] mon_atten_tdb;
        logic       monitor_sel;
    } lsg_path_t;

    // Plain register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lsg_bus_t;

endpackage

// *** verilog/lsg_verify.sv ***
`include "lsg_defines.svh"

module lsg_verify
    import lsg_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic part_ok,
    output logic      pending,
    output logic      running,
    output logic      wrong,
    output logic      done_pulse
);

    lsg_state_t state_r;
    lsg_state_t state_nxt;
    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;
    logic       wrong_r;
    logic       wrong_nxt;
    logic       finish;

    ////////////////////////////////////////////////////////////////////////
    // Check runs once after the line chip is first enabled
    assign finish = (state_r == LSG_RUN) &&
                    (cnt_r == 6'(`LSG_CHECK_CYC - 1));

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        wrong_nxt = wrong_r;
        case (state_r)
            LSG_IDLE: begin
                if (enable) begin
                    state_nxt = LSG_RUN;
                    cnt_nxt   = 6'h00;
                end
            end
            LSG_RUN: begin
                cnt_nxt = cnt_r + 6'h01;
                if (finish) begin
                    state_nxt = LSG_DONE;
                    wrong_nxt = ~part_ok;
                end
            end
            LSG_DONE: state_nxt = LSG_DONE;
            default:  state_nxt = LSG_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= LSG_IDLE;
            cnt_r   <= 6'h00;
            wrong_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            wrong_r <= wrong_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status outputs
    assign pending    = (state_r != LSG_DONE);
    assign running    = (state_r == LSG_RUN);
    assign wrong      = wrong_r;
    assign done_pulse = finish;

endmodule

// *** verilog/lsg_gain_map.sv ***
`include "lsg_defines.svh"

module lsg_gain_map
    import lsg_pkg::*;
(
    input  wire logic [7:0] gain_reg,
    input  wire logic [1:0] legacy,
    input  wire logic       on_hook,
    input  wire logic       monitor_on,
    output lsg_path_t       path
);

    ////////////////////////////////////////////////////////////////////////
    // Step decoding shared by both three-bit selectors
    function automatic logic [4:0] step_hdb(input logic [2:0] code);
        if (code[2])
            step_hdb = 5'h18;            // 12 dB
        else
            step_hdb = {1'b0, code[1:0], 2'h0} + {2'h0, code[1:0], 1'b0};
    endfunction

    function automatic logic [5:0] mon_tdb(input logic [2:0] code);
        case (code[1:0])
            2'h0:    mon_tdb = 6'h00;
            2'h1:    mon_tdb = 6'h0A;    // 1 dB
            2'h2:    mon_tdb = 6'h16;    // 2.2 dB
            default: mon_tdb = 6'h23;    // 3.5 dB
        endcase
        if (code[2])
            mon_tdb = 6'h32;             // 5 dB
    endfunction

    wire logic [2:0] tx_atten_sel;
    wire logic [2:0] rx_gain_sel;
    wire logic       legacy_rx_boost;
    wire logic       legacy_tx_cut;

    assign tx_atten_sel    = gain_reg[`LSG_GN_TXSEL_HI:`LSG_GN_TXSEL_LO];
    assign rx_gain_sel     = gain_reg[`LSG_GN_RXSEL_HI:`LSG_GN_RXSEL_LO];
    assign legacy_rx_boost = legacy[`LSG_ID_RXBOOST];
    assign legacy_tx_cut   = legacy[`LSG_ID_TXCUT];

    ////////////////////////////////////////////////////////////////////////
    // Path settings; legacy bits add on top of the selectors
    assign path.tx_mute       = gain_reg[`LSG_GN_TXMUTE];
    assign path.tx_atten_hdb  = step_hdb(tx_atten_sel)
                              + (legacy_tx_cut ? 5'h06 : 5'h00);
    assign path.rx_mute       = gain_reg[`LSG_GN_RXMUTE];
    assign path.rx_gain_hdb   = step_hdb(rx_gain_sel)
                              + (legacy_rx_boost ? 5'h0C : 5'h00);
    assign path.mon_atten_tdb = mon_tdb(rx_gain_sel);
    assign path.monitor_sel   = on_hook & monitor_on;

endmodule

// *** test/lsg_host.sv ***
// Host software model: plain register port master
module lsg_host (
    input  wire logic       clk,
    output logic [3:0]      addr,
    output logic [7:0]      wdata,
    output logic            wr,
    output logic            rd
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus at time zero
    initial begin
        addr  = 4'h0;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
    end

    // One-cycle write; released lines show the inverse, not stale data
    // Callers keep legacy bits clear while using the selectors
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        addr  <= ~a;
        wdata <= ~d;
        @(posedge clk);
    endtask

    // One-cycle read; released address shows the inverse of the one read
    task automatic rd_reg(input logic [3:0] a);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        addr <= ~a;
        @(posedge clk);
    endtask
endmodule

// *** test/lsg_regs_monitor.sv ***
// Port-level checker for the register bank
module lsg_regs_monitor (
    input wire logic       MCLK,
    input wire logic       RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       LINE_ENABLE,
    input wire logic       LINE_INTL,
    input wire logic [3:0] LINE_REV,
    input wire logic       LINE_PART_OK,
    input wire logic       ON_HOOK,
    input wire logic       MONITOR_ON,
    input wire logic       TX_MUTE,
    input wire logic       RX_MUTE,
    input wire logic       MONITOR_SEL,
    input wire logic       DATA_ENABLE
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    // Data transfer held off for a span of the check
    sequence s_quiet;
        !DATA_ENABLE [*8];
    endsequence
    property p_rdata_idle;
        !$past(RD) |-> RDATA == 8'h00;
    endproperty
    property p_ident;
        RD && ADDR == 4'hD |=>
            RDATA[7:2] == {1'b0, $past(LINE_INTL), $past(LINE_REV)};
    endproperty
    property p_valid_rsv;
        RD && ADDR == 4'hE |=> RDATA[7:3] == 5'h00;
    endproperty
    property p_tx_mute;
        WR && ADDR == 4'hF |-> ##2 TX_MUTE == $past(WDATA[7], 2);
    endproperty
    property p_rx_mute;
        WR && ADDR == 4'hF |-> ##2 RX_MUTE == $past(WDATA[3], 2);
    endproperty
    property p_mon_sel;
        $changed(ON_HOOK && MONITOR_ON) |=>
            MONITOR_SEL == $past(ON_HOOK && MONITOR_ON);
    endproperty
    property p_data_ok;
        $rose(LINE_ENABLE) && LINE_PART_OK |-> s_quiet ##[8:20] DATA_ENABLE;
    endproperty
    property p_data_bad;
        $rose(LINE_ENABLE) && !LINE_PART_OK |->
            s_quiet ##1 s_quiet ##1 s_quiet;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");
    a_ident: assert property (p_ident)
        else $error("identity read wrong");
    a_valid_rsv: assert property (p_valid_rsv)
        else $error("validation spare bits set");
    a_tx_mute: assert property (p_tx_mute)
        else $error("transmit mute wrong");
    a_rx_mute: assert property (p_rx_mute)
        else $error("receive mute wrong");
    a_mon_sel: assert property (p_mon_sel)
        else $error("monitor select wrong");
    a_data_ok: assert property (p_data_ok)
        else $error("data enable timing wrong");
    a_data_bad: assert property (p_data_bad)
        else $error("data enabled for wrong part");
endmodule

bind lsg_regs lsg_regs_monitor u_mon (
    .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .LINE_ENABLE(LINE_ENABLE),
    .LINE_INTL(LINE_INTL), .LINE_REV(LINE_REV),
    .LINE_PART_OK(LINE_PART_OK), .ON_HOOK(ON_HOOK),
    .MONITOR_ON(MONITOR_ON), .TX_MUTE(TX_MUTE), .RX_MUTE(RX_MUTE),
    .MONITOR_SEL(MONITOR_SEL), .DATA_ENABLE(DATA_ENABLE)
);

// *** test/line_side_id_verify_gain_regs_bench.sv ***
module line_side_id_verify_gain_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic       MCLK, RST_N, WR, RD, LINE_ENABLE, LINE_INTL, LINE_PART_OK;
    logic       ON_HOOK, MONITOR_ON, TX_MUTE, RX_MUTE, MONITOR_SEL;
    logic       DATA_ENABLE, IRQ, rd_d;
    logic [3:0] ADDR, LINE_REV;
    logic [7:0] WDATA, RDATA;
    logic [4:0] TX_ATTEN_HDB, RX_GAIN_HDB;
    logic [5:0] MON_ATTEN_TDB;
    logic [7:0] exp_q[$];
    int         n_mismatch, total_checks;

    // Clock, 4 ns period
    initial MCLK = 1'b0;
    always #2 MCLK = ~MCLK;

    lsg_host host (.clk(MCLK), .addr(ADDR), .wdata(WDATA), .wr(WR),
                   .rd(RD));
    lsg_regs dut (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA), .LINE_ENABLE(LINE_ENABLE),
        .LINE_INTL(LINE_INTL), .LINE_REV(LINE_REV),
        .LINE_PART_OK(LINE_PART_OK), .ON_HOOK(ON_HOOK),
        .MONITOR_ON(MONITOR_ON), .TX_MUTE(TX_MUTE),
        .TX_ATTEN_HDB(TX_ATTEN_HDB), .RX_MUTE(RX_MUTE),
        .RX_GAIN_HDB(RX_GAIN_HDB), .MON_ATTEN_TDB(MON_ATTEN_TDB),
        .MONITOR_SEL(MONITOR_SEL), .DATA_ENABLE(DATA_ENABLE), .IRQ(IRQ));

    task automatic chk(input string w, input logic [7:0] e,
                       input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask

    // Note the expected read data, then issue the read
    task automatic rdx(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd_reg(a);
    endtask

    task automatic settle;
        repeat (2) @(posedge MCLK);
        #1;
    endtask

    task automatic do_reset(input logic ok);
        RST_N        <= 1'b0;
        LINE_ENABLE  <= 1'b0;
        ON_HOOK      <= 1'b0;
        MONITOR_ON   <= 1'b0;
        LINE_PART_OK <= ok;
        repeat (8) @(posedge MCLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge MCLK);
    endtask

    function automatic logic [4:0] hdb(input logic [2:0] c);
        return c[2] ? 5'h18 : 5'(c * 6);
    endfunction

    // Read data watcher: oldest note against the returned byte
    always @(posedge MCLK) rd_d <= RD;
    always @(negedge MCLK) begin
        if (rd_d) chk("rdata", exp_q.pop_front(), RDATA);
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog
    initial begin
        #20000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] g;
        logic [2:0] mi;
        logic       s;
        logic [5:0] mon [5];
        mon = '{6'h00, 6'h0A, 6'h16, 6'h23, 6'h32};
        void'($urandom(32'h73be));
        RST_N = 1'b0;
        rd_d = 1'b0;
        LINE_INTL = 1'($urandom);
        LINE_REV = 4'($urandom);
        do_reset(1'b1);
        rdx(4'hF, 8'h00);
        rdx(4'hD, {1'b0, LINE_INTL, LINE_REV, 2'h0});
        host.wr_reg(4'hD, 8'hFF);
        rdx(4'hD, {1'b0, LINE_INTL, LINE_REV, 2'h3});
        settle();
        chk("tx_atten", 8'h06, TX_ATTEN_HDB);
        chk("rx_gain", 8'h0C, RX_GAIN_HDB);
        @(posedge MCLK);
        host.wr_reg(4'h5, 8'hFF);
        rdx(4'h5, 8'h00);
        host.wr_reg(4'hD, 8'h00);
        $display("test ident done");
        rdx(4'hE, 8'h04);
        LINE_ENABLE <= 1'b1;
        repeat (2) @(posedge MCLK);
        rdx(4'hE, 8'h06);
        repeat (30) @(posedge MCLK);
        rdx(4'hE, 8'h00);
        rdx(4'h0, 8'h01);
        settle();
        chk("data_en", 8'h01, DATA_ENABLE);
        chk("irq_masked", 8'h00, IRQ);
        @(posedge MCLK);
        host.wr_reg(4'h1, 8'h01);
        settle();
        chk("irq_set", 8'h01, IRQ);
        @(posedge MCLK);
        host.wr_reg(4'h0, 8'h01);
        settle();
        chk("irq_clr", 8'h00, IRQ);
        @(posedge MCLK);
        $display("test check done");
        for (int i = 0; i < 8; i++) begin
            g = {1'($urandom), 3'(i), 1'($urandom), 3'(7 - i)};
            // Hook and monitor pins walk all four combinations
            s  = i[0] & (~i[1] | i[2]);
            mi = g[2] ? 3'h4 : {1'b0, g[1:0]};
            ON_HOOK <= i[0];
            MONITOR_ON <= ~i[1] | i[2];
            host.wr_reg(4'hF, g);
            rdx(4'hF, g);
            settle();
            chk("tx_mute", g[7], TX_MUTE);
            chk("rx_mute", g[3], RX_MUTE);
            chk("tx_atten", hdb(g[6:4]), TX_ATTEN_HDB);
            chk("mon_sel", s, MONITOR_SEL);
            if (s)
                chk("mon", mon[mi], MON_ATTEN_TDB);
            else
                chk("rx_gain", hdb(g[2:0]), RX_GAIN_HDB);
            @(posedge MCLK);
        end
        $display("test gain done");
        do_reset(1'b0);
        LINE_ENABLE <= 1'b1;
        repeat (40) @(posedge MCLK);
        rdx(4'hE, 8'h01);
        rdx(4'h0, 8'h03);
        host.wr_reg(4'hF, 8'h5A);
        rdx(4'hF, 8'h5A);
        settle();
        chk("data_en", 8'h00, DATA_ENABLE);
        $display("test wrong part done");
        tally_and_finish();
    end
endmodule
